// *** rtl/sbs_spi_slave.sv ***
// Purpose: serial slave joining an off-chip master to byte streams
// Assumes: mode with clock idle low, data launched on rise, sampled on fall
// Notes:   select may stay low across bytes; sink bytes offered while the
//          holding slot is full are dropped, since there is no backpressure
`timescale 1ns/1ps
module sbs_spi_slave
    import sbs_pkg::*;
#(
    parameter int SYNC_DEPTH = SYNC_DEPTH_DEF
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              sclk,
    input  wire logic              mosi,
    input  wire logic              slave_select_n,
    output logic                   miso,
    output logic                   miso_oe,
    output logic [BYTE_W-1:0]      src_data,
    output logic                   src_valid,
    input  wire logic [BYTE_W-1:0] snk_data,
    input  wire logic              snk_valid
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       mosi_s;
    logic       ssn_s;
    logic       sclk_last_q;
    logic       sclk_last_d;
    logic       rise;
    logic       fall;

    // depth set at build time; each stage adds a clock of latency
    sbs_sync #(
        .DEPTH (SYNC_DEPTH),
        .WIDTH (3)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        // select enters inverted so a cleared chain reads as deselected;
        // otherwise the first edges after reset would see a false select
        .din     ({sclk, mosi, ~slave_select_n}),
        .dout    (pins_s)
    );

    assign sclk_s      = pins_s[2];
    assign mosi_s      = pins_s[1];
    assign ssn_s       = ~pins_s[0];
    assign sclk_last_d = sclk_s;
    // polarity zero: leading edge rises, trailing edge falls
    assign rise        = sclk_s & ~sclk_last_q;
    assign fall        = ~sclk_s & sclk_last_q;

    ////////////////////////////////////////////////////////////////////////
    // bit sequencing
    sbs_state_t            st_q;
    sbs_state_t            st_d;
    logic [BIT_CNT_W-1:0]  bit_q;
    logic [BIT_CNT_W-1:0]  bit_d;
    logic                  load;
    logic                  byte_done;

    always_comb begin
        st_d  = st_q;
        bit_d = bit_q;
        if (ssn_s) begin
            st_d  = SBS_ST_IDLE;
            bit_d = BIT_FIRST;
        end else begin
            st_d = SBS_ST_ACTIVE;
            if (st_q == SBS_ST_ACTIVE && fall) begin
                bit_d = bit_q + 3'h1;
            end
        end
    end

    assign load      = (st_q == SBS_ST_ACTIVE) && !ssn_s && rise && (bit_q == BIT_FIRST);
    assign byte_done = (st_q == SBS_ST_ACTIVE) && !ssn_s && fall && (bit_q == BIT_LAST);

    ////////////////////////////////////////////////////////////////////////
    // receive path: sample on falling edge, msb first, then decode
    logic [BYTE_W-1:0] rx_sh_q;
    logic [BYTE_W-1:0] rx_sh_d;
    logic [BYTE_W-1:0] rx_byte;
    logic              esc_q;
    logic              esc_d;
    logic [BYTE_W-1:0] src_data_d;
    logic              src_valid_d;

    assign rx_byte = {rx_sh_q[BYTE_W-2:0], mosi_s};

    always_comb begin
        rx_sh_d     = rx_sh_q;
        esc_d       = esc_q;
        src_data_d  = src_data;
        src_valid_d = 1'b0;
        if ((st_q == SBS_ST_ACTIVE) && !ssn_s && fall) begin
            rx_sh_d = rx_byte;
        end
        if (byte_done) begin
            if (esc_q) begin
                src_data_d  = rx_byte ^ ESC_MASK;
                src_valid_d = 1'b1;
                esc_d       = 1'b0;
            end else if (rx_byte == IDLE_CODE) begin
                src_valid_d = 1'b0;
            end else if (rx_byte == ESC_CODE) begin
                esc_d = 1'b1;
            end else begin
                src_data_d  = rx_byte;
                src_valid_d = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit path: launch on rising edge, msb first, escape and idle fill
    logic [BYTE_W-1:0] hold_q;
    logic [BYTE_W-1:0] hold_d;
    logic              hold_v_q;
    logic              hold_v_d;
    logic              pend_q;
    logic              pend_d;
    logic [BYTE_W-1:0] pend_byte_q;
    logic [BYTE_W-1:0] pend_byte_d;
    logic [BYTE_W-1:0] tx_sh_q;
    logic [BYTE_W-1:0] tx_sh_d;
    logic [BYTE_W-1:0] tx_byte;
    logic              hold_special;
    logic              miso_d;
    logic              miso_oe_d;

    assign hold_special = (hold_q == IDLE_CODE) || (hold_q == ESC_CODE);

    always_comb begin
        hold_d      = hold_q;
        hold_v_d    = hold_v_q;
        pend_d      = pend_q;
        pend_byte_d = pend_byte_q;
        tx_sh_d     = tx_sh_q;
        miso_d      = miso;
        tx_byte     = IDLE_CODE;
        if (pend_q) begin
            tx_byte = pend_byte_q;
        end else if (hold_v_q) begin
            tx_byte = hold_special ? ESC_CODE : hold_q;
        end
        if (load) begin
            if (pend_q) begin
                pend_d = 1'b0;
            end else if (hold_v_q) begin
                hold_v_d = 1'b0;
                if (hold_special) begin
                    pend_d      = 1'b1;
                    pend_byte_d = hold_q ^ ESC_MASK;
                end
            end
            miso_d  = tx_byte[BYTE_W-1];
            tx_sh_d = {tx_byte[BYTE_W-2:0], 1'b0};
        end else if ((st_q == SBS_ST_ACTIVE) && !ssn_s && rise) begin
            miso_d  = tx_sh_q[BYTE_W-1];
            tx_sh_d = {tx_sh_q[BYTE_W-2:0], 1'b0};
        end
        // new sink byte wins over the slot being emptied this cycle
        if (snk_valid && (!hold_v_q || hold_v_d == 1'b0)) begin
            hold_d   = snk_data;
            hold_v_d = 1'b1;
        end
        // never stalls the master: the link runs regardless of the streams
        miso_oe_d = !ssn_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclk_last_q <= 1'b0;
            st_q        <= SBS_ST_IDLE;
            bit_q       <= BIT_FIRST;
            rx_sh_q     <= BYTE_RST;
            esc_q       <= 1'b0;
            src_data    <= BYTE_RST;
            src_valid   <= 1'b0;
            hold_q      <= BYTE_RST;
            hold_v_q    <= 1'b0;
            pend_q      <= 1'b0;
            pend_byte_q <= BYTE_RST;
            tx_sh_q     <= BYTE_RST;
            miso        <= 1'b0;
            miso_oe     <= 1'b0;
        end else begin
            sclk_last_q <= sclk_last_d;
            st_q        <= st_d;
            bit_q       <= bit_d;
            rx_sh_q     <= rx_sh_d;
            esc_q       <= esc_d;
            src_data    <= src_data_d;
            src_valid   <= src_valid_d;
            hold_q      <= hold_d;
            hold_v_q    <= hold_v_d;
            pend_q      <= pend_d;
            pend_byte_q <= pend_byte_d;
            tx_sh_q     <= tx_sh_d;
            miso        <= miso_d;
            miso_oe     <= miso_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_src_one_cycle: assert property (
        @(posedge mclk) disable iff (sys_rst)
        src_valid |=> !src_valid [*2])
        else $error("source valid held longer than one cycle");

    chk_idle_dropped: assert property (
        @(posedge mclk) disable iff (sys_rst)
        byte_done && !esc_q && (rx_byte == IDLE_CODE) |=> !src_valid)
        else $error("idle code forwarded to source");

    chk_escape_decode: assert property (
        @(posedge mclk) disable iff (sys_rst)
        byte_done && esc_q |=> src_valid && (src_data == ($past(rx_byte) ^ ESC_MASK)))
        else $error("escaped byte not decoded");

    chk_escape_swallow: assert property (
        @(posedge mclk) disable iff (sys_rst)
        byte_done && !esc_q && (rx_byte == ESC_CODE) |=> !src_valid && esc_q)
        else $error("escape code not swallowed");

    chk_select_idle: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ssn_s |=> (st_q == SBS_ST_IDLE) && (bit_q == BIT_FIRST) && !miso_oe)
        else $error("active without select");

    chk_msb_launch: assert property (
        @(posedge mclk) disable iff (sys_rst)
        load |=> (miso == $past(tx_byte[BYTE_W-1])) && miso_oe)
        else $error("first bit out is not the msb");

    chk_idle_fill: assert property (
        @(posedge mclk) disable iff (sys_rst)
        load && !pend_q && !hold_v_q |=> (tx_sh_q == {IDLE_CODE[BYTE_W-2:0], 1'b0}))
        else $error("idle fill not sent");

    chk_escape_insert: assert property (
        @(posedge mclk) disable iff (sys_rst)
        load && !pend_q && hold_v_q && hold_special
        |=> pend_q && (pend_byte_q == ($past(hold_q) ^ ESC_MASK)) && !miso)
        else $error("escape not inserted for special byte");

    chk_sink_consumed: assert property (
        @(posedge mclk) disable iff (sys_rst)
        load && !pend_q && hold_v_q && !snk_valid |=> !hold_v_q)
        else $error("sink byte not taken at byte start");

    chk_shift_on_rise: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (st_q == SBS_ST_ACTIVE) && !ssn_s && !rise |=> $stable(miso))
        else $error("master-in changed away from rising edge");
endmodule

// *** pkg/sbs_pkg.sv ***
// Purpose: shared constants and types for the serial byte-stream slave
// Assumes: one system clock more than six times as fast as the serial clock at the default sync depth
// Notes:   special codes and the escape mask live here only
//
// Notes on behaviour
// - stay idle until select goes low, then shift in master-out bits.
// - only clock phase one, clock polarity zero is supported by both ends.
// - full duplex, receive and transmit together, with no way to stall.
// - both streams carry one eight-bit symbol, no backpressure, channel, error, packets.
// - pack received bits into bytes and drop each idle code byte not following an escape code.
// - drop escape code, forward next byte exclusive-ORed with escape mask.
// - each decoded byte appears on the source with valid high one clock.
// - while receiving, send sink bytes concurrently on the master-in line.
// - with no sink byte waiting, send the idle code instead.
// - a special byte is sent as escape code then byte exclusive-ORed with mask.
// - both directions shift most significant bit first.
// - synchroniser chain depth is a build parameter; deeper adds latency.
package sbs_pkg;
    localparam int          BYTE_W         = 8;
    localparam int          BIT_CNT_W      = 3;
    localparam int          SYNC_DEPTH_DEF = 2;
    localparam logic [7:0]  IDLE_CODE      = 8'h4A;
    localparam logic [7:0]  ESC_CODE       = 8'h4D;
    localparam logic [7:0]  ESC_MASK       = 8'h20;
    localparam logic [2:0]  BIT_FIRST      = 3'h0;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [7:0]  BYTE_RST       = 8'h00;

    typedef enum logic {
        SBS_ST_IDLE,
        SBS_ST_ACTIVE
    } sbs_state_t;
endpackage

// *** rtl/sbs_sync.sv ***
// Purpose: multi-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sbs_sync
    import sbs_pkg::*;
#(
    parameter int DEPTH = SYNC_DEPTH_DEF,
    parameter int WIDTH = 3
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] chain_q [DEPTH];
    logic [WIDTH-1:0] chain_d [DEPTH];

    always_comb begin
        chain_d[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            chain_d[i] = chain_q[i-1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    chain_q[g] <= '0;
                end else begin
                    chain_q[g] <= chain_d[g];
                end
            end
        end
    endgenerate

    assign dout = chain_q[DEPTH-1];
endmodule

// *** bench/sbs_master_model.sv ***
// Purpose: behavioural serial master driving the slave's link pins
// Assumes: clock idle low, data launched on rise, sampled on fall
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ps
module sbs_master_model #(
    parameter int HALF_NS = 80
) (
    output logic      sclk,
    output logic      mosi,
    output logic      slave_select_n,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // single slave only, no chaining of miso into another mosi
    initial begin
        sclk           = 1'b0;
        mosi           = 1'b1;
        slave_select_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] tx, input int lead_ns, input int nbits,
                        output logic [7:0] rx);
        rx             = 8'h00;
        slave_select_n = 1'b0;
        #(lead_ns);
        for (int i = 7; i > 7 - nbits; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #(HALF_NS);
            sclk  = 1'b0;
            rx[i] = (miso_oe === 1'b1) ? miso : 1'bx;
            #(HALF_NS);
        end
        slave_select_n = 1'b1;
        mosi           = ~mosi;
        #(2 * HALF_NS);
    endtask

    task automatic stray(input int n);
        repeat (n) begin
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
            #(HALF_NS);
        end
    endtask
endmodule

// *** bench/tb_spi_slave_byte_stream.sv ***
// Purpose: self-checking bench for the serial byte-stream slave
// Assumes: master model paces the link at 160 ns per bit
// Notes:   a monitor queues source bytes, each scenario judges them
`timescale 1ns/1ps
module tb_spi_slave_byte_stream
    import sbs_pkg::*;
;
    logic              mclk;
    logic              sys_rst;
    logic              sclk;
    logic              mosi;
    logic              slave_select_n;
    logic              miso;
    logic              miso_oe;
    logic              src_valid;
    logic              snk_valid;
    logic              prev_valid;
    logic [BYTE_W-1:0] src_data;
    logic [BYTE_W-1:0] snk_data;
    logic [7:0]        src_q[$];
    int                bad_count;
    int                n_compared;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    sbs_spi_slave #(.SYNC_DEPTH(2)) dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .mosi(mosi),
        .slave_select_n(slave_select_n), .miso(miso), .miso_oe(miso_oe),
        .src_data(src_data), .src_valid(src_valid),
        .snk_data(snk_data), .snk_valid(snk_valid)
    );

    sbs_master_model mdl_u (
        .sclk(sclk), .mosi(mosi), .slave_select_n(slave_select_n),
        .miso(miso), .miso_oe(miso_oe)
    );

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge mclk) begin
        prev_valid <= src_valid;
        if (src_valid === 1'b1) begin
            src_q.push_back(src_data);
            chk({7'h00, prev_valid}, 8'h00);
        end
    end

    task automatic frame(input logic [7:0] tx, input int lead, input logic [7:0] exp);
        logic [7:0] rx;
        mdl_u.xfer(tx, lead, 8, rx);
        chk(rx, exp);
    endtask

    task automatic src_chk(input int n, input logic [7:0] exp);
        chk(8'(src_q.size()), 8'(n));
        if (n > 0 && src_q.size() > 0) begin
            chk(src_q.pop_front(), exp);
        end
        src_q.delete();
    endtask

    // sink has no ready, so one byte is offered per frame
    task automatic offer(input logic [7:0] b);
        @(negedge mclk);
        snk_data  = b;
        snk_valid = 1'b1;
        @(negedge mclk);
        snk_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    // every cycle straight after release, while the pin chains fill
    task automatic t_reset;
        repeat (6) begin
            @(negedge mclk);
            chk({5'h00, miso, miso_oe, src_valid}, 8'h00);
        end
        chk(src_data, BYTE_RST);
    endtask

    task automatic t_idle;
        frame(IDLE_CODE, 80, IDLE_CODE);
        src_chk(0, 8'h00);
    endtask

    task automatic t_duplex;
        offer(8'hA5);
        frame(8'h3C, 400, 8'hA5);
        src_chk(1, 8'h3C);
        offer(8'h00);
        frame(8'hFF, 60, 8'h00);
        src_chk(1, 8'hFF);
    endtask

    task automatic t_rx_esc;
        logic [7:0] codes[3] = '{IDLE_CODE, ESC_CODE, 8'h11};
        foreach (codes[k]) begin
            frame(ESC_CODE, 80, IDLE_CODE);
            src_chk(0, 8'h00);
            frame(codes[k] ^ ESC_MASK, 80, IDLE_CODE);
            src_chk(1, codes[k]);
        end
    endtask

    task automatic t_tx_esc;
        logic [7:0] codes[2] = '{IDLE_CODE, ESC_CODE};
        foreach (codes[k]) begin
            offer(codes[k]);
            frame(IDLE_CODE, 80, ESC_CODE);
            frame(IDLE_CODE, 80, codes[k] ^ ESC_MASK);
        end
        src_chk(0, 8'h00);
    endtask

    // stray clocks and a cut-short frame must leave no trace
    task automatic t_stray;
        logic [7:0] rx;
        mdl_u.stray(4);
        mdl_u.xfer(8'hF0, 80, 3, rx);
        chk(rx, 8'h40);
        src_chk(0, 8'h00);
        frame(8'h81, 80, IDLE_CODE);
        src_chk(1, 8'h81);
    endtask

    ////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        sys_rst    = 1'b1;
        snk_valid  = 1'b0;
        snk_data   = 8'h00;
        bad_count  = 0;
        n_compared = 0;
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_idle();
        t_duplex();
        t_rx_esc();
        t_tx_esc();
        t_stray();
        wrap_up();
    end
endmodule
